// ===== design/sample_clock_divider_delay.sv
`timescale 1ns/1ps
// How it works
// - Input clock divided by 1, 2 or 4 per divider select register.
// - Valid reference pulse loads the divider with a programmable state.
// - Half-period phase delay enabled through its own register.
// - Half-period delay writes never disturb the serial link.
// - Three-bit field picks fine alone or fine plus superfine; 16 or 192 steps.
// - Eight-bit fine delay value chooses among 16 or 192 steps.
// - Eight-bit superfine value, up to 128 steps of 0.25 ps.
// - Superfine applies only for control codes 0x2 or 0x6.
// - Delay changes act right after the enabling write.
// - Turning fine delay on pulses a sample datapath reset.
// - Fine and superfine value writes never disturb the serial link.
// - Duty stabilisers default on in fast grade, two control registers.
// - Divided clock to converter has 50% duty cycle when dividing by 2 or 4; held high at divide by 1.
// - Samples taken on rising edge of divided clock.
module sample_clock_divider_delay #(
  parameter bit FAST_GRADE = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire logic [clock_cond_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic [clock_cond_pkg::DATA_W-1:0] cfg_wr_data,
  output logic [clock_cond_pkg::DATA_W-1:0] cfg_rd_data,
  input wire logic sysref,
  output logic div_clk,
  output logic sample_en,
  output logic half_delay_sel,
  output clock_cond_pkg::delay_drive_t delay_drive,
  output logic datapath_rst,
  output logic link_disturb,
  output logic duty_stabilizer_first,
  output logic duty_stabilizers_ok,
  output logic duty_stabilizer_second
);
  import clock_cond_pkg::*;

  logic [7:0] ratio_reg;
  logic [7:0] half_reg;
  logic [7:0] sync_state_reg;
  logic [7:0] delay_ctrl_reg;
  logic [7:0] superfine_reg;
  logic [7:0] fine_reg;
  logic [7:0] duty_a_reg;
  logic [7:0] duty_b_reg;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic [1:0] period_reg;
  logic [1:0] period_next;
  logic sysref_d_reg;
  logic sysref_rise;
  logic [3:0] dp_rst_cnt_reg;
  logic [7:0] rd_next;
  logic fine_on_next;

  function automatic logic [1:0] ratio_period(input logic [7:0] code);
    unique case (code)
      RATIO_DIV2: ratio_period = PERIOD_DIV2;
      RATIO_DIV4: ratio_period = PERIOD_DIV4;
      default: ratio_period = PERIOD_DIV1;
    endcase
  endfunction

  function automatic logic wr_hit(input logic en, input logic [15:0] a, input logic [15:0] ofs);
    wr_hit = en && (a == ofs);
  endfunction

  // Configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ratio_reg <= RST_DIVIDE_RATIO;
      half_reg <= RST_HALF_DELAY;
      sync_state_reg <= RST_SYNC_STATE;
      delay_ctrl_reg <= RST_DELAY_CTRL;
      superfine_reg <= RST_DELAY_VALUE;
      fine_reg <= RST_DELAY_VALUE;
    end else begin
      if (wr_hit(cfg_wr_en, cfg_addr, OFS_DIVIDE_RATIO)) begin
        ratio_reg <= cfg_wr_data;
      end
      if (wr_hit(cfg_wr_en, cfg_addr, OFS_HALF_DELAY)) begin
        half_reg <= cfg_wr_data;
      end
      if (wr_hit(cfg_wr_en, cfg_addr, OFS_SYNC_STATE)) begin
        sync_state_reg <= cfg_wr_data;
      end
      if (wr_hit(cfg_wr_en, cfg_addr, OFS_DELAY_CTRL)) begin
        delay_ctrl_reg <= cfg_wr_data;
      end
      if (wr_hit(cfg_wr_en, cfg_addr, OFS_SUPERFINE)) begin
        superfine_reg <= cfg_wr_data;
      end
      if (wr_hit(cfg_wr_en, cfg_addr, OFS_FINE)) begin
        fine_reg <= cfg_wr_data;
      end
    end
  end

  // Duty stabiliser controls, on from reset in the fast grade
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      duty_a_reg <= FAST_GRADE ? RST_DUTY_ON : RST_DUTY_OFF;
      duty_b_reg <= FAST_GRADE ? RST_DUTY_ON : RST_DUTY_OFF;
    end else begin
      if (wr_hit(cfg_wr_en, cfg_addr, OFS_DUTY_A)) begin
        duty_a_reg <= cfg_wr_data;
      end
      if (wr_hit(cfg_wr_en, cfg_addr, OFS_DUTY_B)) begin
        duty_b_reg <= cfg_wr_data;
      end
    end
  end

  assign duty_stabilizer_first = duty_a_reg[DUTY_EN_BIT];
  assign duty_stabilizer_second = duty_b_reg[DUTY_EN_BIT];
  assign duty_stabilizers_ok = duty_stabilizer_first && duty_stabilizer_second;

  // Reference pulse edge detect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sysref_d_reg <= 1'b0;
    end else begin
      sysref_d_reg <= sysref;
    end
  end

  assign sysref_rise = sysref && !sysref_d_reg;

  // New ratio is adopted only at a wrap or a reference pulse, so no runt pulse
  always_comb begin
    period_next = period_reg;
    cnt_next = cnt_reg + 2'h1;
    if (sysref_rise) begin
      period_next = ratio_period(ratio_reg);
      cnt_next = sync_state_reg[1:0] & period_next;
    end else if (cnt_reg == period_reg) begin
      period_next = ratio_period(ratio_reg);
      cnt_next = 2'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 2'h0;
      period_reg <= PERIOD_DIV1;
      div_clk <= 1'b1;
      sample_en <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      period_reg <= period_next;
      div_clk <= (cnt_next <= (period_next >> 1));
      sample_en <= (cnt_next == 2'h0);
    end
  end

  assign half_delay_sel = half_reg[HALF_EN_BIT];

  // Delay drive to the analog delay line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      delay_drive <= '0;
    end else begin
      delay_drive.fine_on <= (delay_ctrl_reg[2:0] != DELAY_OFF);
      delay_drive.fine_192 <= delay_ctrl_reg[DELAY_192_BIT];
      delay_drive.superfine_on <= (delay_ctrl_reg[2:0] == DELAY_SUPERFINE_A) ||
                                  (delay_ctrl_reg[2:0] == DELAY_SUPERFINE_B);
      if (delay_ctrl_reg[DELAY_192_BIT]) begin
        delay_drive.fine_code <= (fine_reg > FINE192_MAX) ? FINE192_MAX : fine_reg;
      end else begin
        delay_drive.fine_code <= (fine_reg > FINE16_MAX) ? FINE16_MAX : fine_reg;
      end
      delay_drive.superfine_code <= (superfine_reg > SUPERFINE_MAX) ? SUPERFINE_MAX[6:0] : superfine_reg[6:0];
    end
  end

  // Datapath reset when the fine delay goes from off to on
  assign fine_on_next = (cfg_wr_data[2:0] != DELAY_OFF);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dp_rst_cnt_reg <= 4'h0;
    end else if (wr_hit(cfg_wr_en, cfg_addr, OFS_DELAY_CTRL) && fine_on_next &&
                 (delay_ctrl_reg[2:0] == DELAY_OFF)) begin
      dp_rst_cnt_reg <= DP_RST_CYCLES;
    end else if (dp_rst_cnt_reg != 4'h0) begin
      dp_rst_cnt_reg <= dp_rst_cnt_reg - 4'h1;
    end
  end

  assign datapath_rst = (dp_rst_cnt_reg != 4'h0);
  // No configuration write in this block retrains the serial link
  assign link_disturb = 1'b0;

  // Read back
  always_comb begin
    unique case (cfg_addr)
      OFS_DIVIDE_RATIO: rd_next = ratio_reg;
      OFS_HALF_DELAY: rd_next = half_reg;
      OFS_SYNC_STATE: rd_next = sync_state_reg;
      OFS_DIV_STATUS: rd_next = {3'h0, datapath_rst, period_reg, cnt_reg};
      OFS_DELAY_CTRL: rd_next = delay_ctrl_reg;
      OFS_SUPERFINE: rd_next = superfine_reg;
      OFS_FINE: rd_next = fine_reg;
      OFS_DUTY_A: rd_next = duty_a_reg;
      OFS_DUTY_B: rd_next = duty_b_reg;
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_rd_data <= 8'h00;
    end else if (cfg_rd_en) begin
      cfg_rd_data <= rd_next;
    end
  end

  // Checks
  property p_div2_toggle;
    @(posedge clk) disable iff (rst)
      (period_reg == PERIOD_DIV2 && $past(period_reg) == PERIOD_DIV2 && !$past(sysref_rise))
      |-> (div_clk != $past(div_clk));
  endproperty
  a_div2_toggle: assert property (p_div2_toggle) else $error("div2 clock did not toggle");

  property p_div4_duty;
    @(posedge clk) disable iff (rst)
      (period_reg == PERIOD_DIV4 && cnt_reg == 2'h0 && !sysref_rise) ##1 (!sysref_rise)[*2]
      |-> (!div_clk && $past(div_clk) && $past(div_clk, 2)) ##1 !div_clk;
  endproperty
  a_div4_duty: assert property (p_div4_duty) else $error("div4 clock not half high");

  property p_div1_pass;
    @(posedge clk) disable iff (rst)
      (period_reg == PERIOD_DIV1) |-> (div_clk && sample_en);
  endproperty
  a_div1_pass: assert property (p_div1_pass) else $error("div1 not passed through");

  property p_sync_load;
    @(posedge clk) disable iff (rst)
      sysref_rise |=> (cnt_reg == (($past(sync_state_reg[1:0])) & ratio_period($past(ratio_reg))));
  endproperty
  a_sync_load: assert property (p_sync_load) else $error("reference did not load divider");

  property p_sample_rise;
    @(posedge clk) disable iff (rst)
      (sample_en && period_reg != PERIOD_DIV1) |-> (div_clk && cnt_reg == 2'h0);
  endproperty
  a_sample_rise: assert property (p_sample_rise) else $error("sample not at rising edge");

  property p_ratio_hold;
    @(posedge clk) disable iff (rst)
      ($past(cnt_reg) != $past(period_reg) && !$past(sysref_rise)) |-> $stable(period_reg);
  endproperty
  a_ratio_hold: assert property (p_ratio_hold) else $error("ratio changed mid period");

  property p_superfine_codes;
    @(posedge clk) disable iff (rst)
      delay_drive.superfine_on |-> ($past(delay_ctrl_reg[2:0]) == DELAY_SUPERFINE_A ||
                                    $past(delay_ctrl_reg[2:0]) == DELAY_SUPERFINE_B);
  endproperty
  a_superfine_codes: assert property (p_superfine_codes) else $error("superfine on with wrong code");

  property p_delay_immediate;
    @(posedge clk) disable iff (rst)
      (wr_hit(cfg_wr_en, cfg_addr, OFS_FINE) && cfg_wr_data <= FINE16_MAX)
      ##1 !wr_hit(cfg_wr_en, cfg_addr, OFS_FINE) |=> (delay_drive.fine_code == $past(fine_reg));
  endproperty
  a_delay_immediate: assert property (p_delay_immediate) else $error("fine delay late");

  property p_fine_limit;
    @(posedge clk) disable iff (rst)
      (delay_drive.fine_code <= FINE192_MAX) && (delay_drive.fine_192 || delay_drive.fine_code <= FINE16_MAX);
  endproperty
  a_fine_limit: assert property (p_fine_limit) else $error("fine code beyond step count");

  property p_dp_reset;
    @(posedge clk) disable iff (rst)
      (wr_hit(cfg_wr_en, cfg_addr, OFS_DELAY_CTRL) && cfg_wr_data[2:0] != DELAY_OFF &&
       delay_ctrl_reg[2:0] == DELAY_OFF)
      |=> datapath_rst[*4] ##1 !datapath_rst;
  endproperty
  a_dp_reset: assert property (p_dp_reset) else $error("datapath reset pulse wrong");

  property p_value_no_reset;
    @(posedge clk) disable iff (rst)
      (!datapath_rst && wr_hit(cfg_wr_en, cfg_addr, OFS_FINE)) |=> !datapath_rst && !link_disturb;
  endproperty
  a_value_no_reset: assert property (p_value_no_reset) else $error("value write disturbed path");

  property p_half_no_reset;
    @(posedge clk) disable iff (rst)
      (!datapath_rst && wr_hit(cfg_wr_en, cfg_addr, OFS_HALF_DELAY)) |=> !datapath_rst && !link_disturb;
  endproperty
  a_half_no_reset: assert property (p_half_no_reset) else $error("half delay write disturbed path");

  property p_sf_limit;
    @(posedge clk) disable iff (rst)
      delay_drive.superfine_on |-> (delay_drive.superfine_code ==
        (($past(superfine_reg) > SUPERFINE_MAX) ? SUPERFINE_MAX[6:0] : $past(superfine_reg[6:0])));
  endproperty
  a_sf_limit: assert property (p_sf_limit) else $error("superfine out of range");

  property p_dp_rise_cause;
    @(posedge clk) disable iff (rst)
      $rose(datapath_rst) |-> ($past(delay_ctrl_reg[2:0]) == DELAY_OFF) && (delay_ctrl_reg[2:0] != DELAY_OFF);
  endproperty
  a_dp_rise_cause: assert property (p_dp_rise_cause) else $error("datapath reset without fine enable");

  property p_half_follow;
    @(posedge clk) disable iff (rst)
      wr_hit(cfg_wr_en, cfg_addr, OFS_HALF_DELAY) |=> (half_delay_sel == $past(cfg_wr_data[HALF_EN_BIT]));
  endproperty
  a_half_follow: assert property (p_half_follow) else $error("half delay select not applied");

  property p_duty_first;
    @(posedge clk) disable iff (rst)
      wr_hit(cfg_wr_en, cfg_addr, OFS_DUTY_A) |=> (duty_stabilizer_first == $past(cfg_wr_data[DUTY_EN_BIT]));
  endproperty
  a_duty_first: assert property (p_duty_first) else $error("first stabiliser enable not applied");

  property p_duty_second;
    @(posedge clk) disable iff (rst)
      wr_hit(cfg_wr_en, cfg_addr, OFS_DUTY_B) |=> (duty_stabilizer_second == $past(cfg_wr_data[DUTY_EN_BIT]));
  endproperty
  a_duty_second: assert property (p_duty_second) else $error("second stabiliser enable not applied");

  property p_div2_sample;
    @(posedge clk) disable iff (rst)
      (period_reg == PERIOD_DIV2 && sample_en && !sysref_rise) |=> (!sample_en && !div_clk);
  endproperty
  a_div2_sample: assert property (p_div2_sample) else $error("div2 sample strobe too long");

  c_sync: cover property (@(posedge clk) disable iff (rst) sysref_rise && period_reg == PERIOD_DIV4);
  c_ratio_change: cover property (@(posedge clk) disable iff (rst) $changed(period_reg));
  c_dp_reset: cover property (@(posedge clk) disable iff (rst) $rose(datapath_rst));
  c_superfine: cover property (@(posedge clk) disable iff (rst) $rose(delay_drive.superfine_on));
  c_half: cover property (@(posedge clk) disable iff (rst) $rose(half_delay_sel));

endmodule

// ===== pkg/clock_cond_pkg.sv
package clock_cond_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [15:0] OFS_DIVIDE_RATIO = 16'h0108;
  localparam logic [15:0] OFS_HALF_DELAY = 16'h0109;
  localparam logic [15:0] OFS_SYNC_STATE = 16'h010A;
  localparam logic [15:0] OFS_DIV_STATUS = 16'h010B;
  localparam logic [15:0] OFS_DELAY_CTRL = 16'h0110;
  localparam logic [15:0] OFS_SUPERFINE = 16'h0111;
  localparam logic [15:0] OFS_FINE = 16'h0112;
  localparam logic [15:0] OFS_DUTY_A = 16'h011C;
  localparam logic [15:0] OFS_DUTY_B = 16'h011E;

  // Divide ratio codes
  localparam logic [7:0] RATIO_DIV1 = 8'h00;
  localparam logic [7:0] RATIO_DIV2 = 8'h01;
  localparam logic [7:0] RATIO_DIV4 = 8'h03;

  // Divider terminal counts (ratio minus one)
  localparam logic [1:0] PERIOD_DIV1 = 2'h0;
  localparam logic [1:0] PERIOD_DIV2 = 2'h1;
  localparam logic [1:0] PERIOD_DIV4 = 2'h3;

  // Delay control field
  localparam int DELAY_CODE_W = 3;
  localparam logic [2:0] DELAY_OFF = 3'h0;
  localparam logic [2:0] DELAY_SUPERFINE_A = 3'h2;
  localparam logic [2:0] DELAY_SUPERFINE_B = 3'h6;
  localparam int DELAY_192_BIT = 2;

  // Step limits, largest legal code
  localparam logic [7:0] FINE16_MAX = 8'h0F;
  localparam logic [7:0] FINE192_MAX = 8'hBF;
  localparam logic [7:0] SUPERFINE_MAX = 8'h7F;
  localparam int SUPERFINE_STEP_FS = 250;

  // Reset values
  localparam logic [7:0] RST_DIVIDE_RATIO = 8'h00;
  localparam logic [7:0] RST_HALF_DELAY = 8'h00;
  localparam logic [7:0] RST_SYNC_STATE = 8'h00;
  localparam logic [7:0] RST_DELAY_CTRL = 8'h00;
  localparam logic [7:0] RST_DELAY_VALUE = 8'h00;
  localparam logic [7:0] RST_DUTY_ON = 8'h01;
  localparam logic [7:0] RST_DUTY_OFF = 8'h00;
  localparam int DUTY_EN_BIT = 0;
  localparam int HALF_EN_BIT = 0;

  // Datapath reset pulse length in cycles
  localparam logic [3:0] DP_RST_CYCLES = 4'h4;

  typedef struct packed {
    logic fine_on;
    logic fine_192;
    logic superfine_on;
    logic [7:0] fine_code;
    logic [6:0] superfine_code;
  } delay_drive_t;

endpackage

// ===== test/ref_source.sv
`timescale 1ns/1ps
module ref_source (
  input wire logic clk,
  input wire logic fire,
  output logic sysref
);
  logic hold_reg;
  initial begin
    sysref = 1'b0;
    hold_reg = 1'b0;
  end
  // Two-cycle framing pulse, launched on the falling edge, away from the sampling edge
  always @(negedge clk) begin
    sysref <= fire | hold_reg;
    hold_reg <= fire;
  end
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, (e), (g)); end end
module tb_top;
  import clock_cond_pkg::*;
  localparam logic [15:0] REG_ADDR [8] = '{16'h0108, 16'h0109, 16'h0110, 16'h0111,
    16'h0112, 16'h011C, 16'h011E, 16'h0100};
  localparam logic [7:0] REG_RST [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_wr_en = 1'b0;
  logic cfg_rd_en = 1'b0;
  logic [15:0] cfg_addr = 16'h0000;
  logic [7:0] cfg_wr_data = 8'h00;
  logic fire = 1'b0;
  logic sysref;
  logic [7:0] cfg_rd_data;
  logic div_clk, sample_en, half_delay_sel, datapath_rst, link_disturb;
  logic duty_stabilizer_first, duty_stabilizers_ok, duty_stabilizer_second;
  delay_drive_t delay_drive;
  int n_fail = 0;
  int cmp_count = 0;
  always #25 clk = ~clk;
  sample_clock_divider_delay #(.FAST_GRADE(1'b1)) dut (.clk(clk), .rst(rst), .cfg_wr_en(cfg_wr_en),
    .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
    .sysref(sysref), .div_clk(div_clk), .sample_en(sample_en), .half_delay_sel(half_delay_sel),
    .delay_drive(delay_drive), .datapath_rst(datapath_rst), .link_disturb(link_disturb),
    .duty_stabilizer_first(duty_stabilizer_first), .duty_stabilizers_ok(duty_stabilizers_ok),
    .duty_stabilizer_second(duty_stabilizer_second));
  ref_source src (.clk(clk), .fire(fire), .sysref(sysref));
  task results;
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    cfg_addr = a;
    cfg_wr_data = d;
    cfg_wr_en = 1'b1;
    @(negedge clk);
    cfg_wr_en = 1'b0;
  endtask
  task chk_rd(input string nm, input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    cfg_addr = a;
    cfg_rd_en = 1'b1;
    @(negedge clk);
    cfg_rd_en = 1'b0;
    @(negedge clk);
    `CHK(nm, e, cfg_rd_data)
  endtask
  task t_reset_access;
    `CHK("duty first", 1'b1, duty_stabilizer_first)
    `CHK("duty ok", 1'b1, duty_stabilizers_ok)
    `CHK("div clk", 1'b1, div_clk)
    `CHK("sample en", 1'b1, sample_en)
    for (int i = 0; i < 8; i++)
      chk_rd("reset value", REG_ADDR[i], REG_RST[i]);
    for (int i = 0; i < 8; i++) begin
      wr(REG_ADDR[i], 8'h5A);
      chk_rd("read back", REG_ADDR[i], (i == 7) ? 8'h00 : 8'h5A);
      wr(REG_ADDR[i], REG_RST[i]);
    end
  endtask
  task t_divider;
    logic [7:0] code [4];
    int exp_hi [4];
    int exp_se [4];
    int hi, se;
    code = '{8'h00, 8'h01, 8'h03, 8'h02};
    exp_hi = '{8, 4, 4, 8};
    exp_se = '{8, 4, 2, 8};
    for (int i = 0; i < 4; i++) begin
      wr(OFS_DIVIDE_RATIO, code[i]);
      repeat (8) @(negedge clk);
      hi = 0;
      se = 0;
      repeat (8) begin
        @(negedge clk);
        if (div_clk === 1'b1) hi++;
        if (sample_en === 1'b1) se++;
      end
      `CHK("div clk high count", exp_hi[i], hi)
      `CHK("sample count", exp_se[i], se)
    end
    chk_rd("divider status", OFS_DIV_STATUS, 8'h00);
  endtask
  task measure(input logic [7:0] st, output int d);
    wr(OFS_SYNC_STATE, st);
    repeat (6) @(negedge clk);
    fire <= 1'b1;
    @(negedge clk);
    fire <= 1'b0;
    @(posedge clk);
    d = 0;
    for (int k = 1; k <= 12; k++) begin
      @(posedge clk);
      #1;
      if (k >= 2 && d == 0 && sample_en === 1'b1) d = k;
    end
  endtask
  task t_sync;
    int d0, d2, d0b;
    wr(OFS_DIVIDE_RATIO, RATIO_DIV4);
    repeat (8) @(negedge clk);
    measure(8'h00, d0);
    measure(8'h02, d2);
    measure(8'h00, d0b);
    `CHK("sync repeat", d0, d0b)
    `CHK("sync state offset", 2, (d0 - d2 + 8) % 4)
    chk_rd("sync state", OFS_SYNC_STATE, 8'h00);
  endtask
  task t_delay;
    logic [7:0] fv, sv, fmax, fe;
    logic [6:0] sfe;
    for (int p = 0; p < 2; p++) begin
      fv = p ? 8'hC5 : 8'h0A;
      sv = p ? 8'hFF : 8'h55;
      wr(OFS_FINE, fv);
      wr(OFS_SUPERFINE, sv);
      for (int c = 0; c < 8; c++) begin
        wr(OFS_DELAY_CTRL, 8'(c));
        repeat (2) @(negedge clk);
        fmax = c[2] ? FINE192_MAX : FINE16_MAX;
        fe = (fv > fmax) ? fmax : fv;
        sfe = (sv > SUPERFINE_MAX) ? SUPERFINE_MAX[6:0] : sv[6:0];
        `CHK("fine on", (c != 0), delay_drive.fine_on)
        `CHK("fine 192", c[2], delay_drive.fine_192)
        `CHK("superfine on", (c == 2 || c == 6), delay_drive.superfine_on)
        if (c != 0) `CHK("fine code", fe, delay_drive.fine_code)
        if (c == 2 || c == 6) `CHK("superfine code", sfe, delay_drive.superfine_code)
      end
    end
  endtask
  task count_dp(input logic [7:0] code, input int e);
    int n;
    wr(OFS_DELAY_CTRL, code);
    n = 0;
    repeat (10) begin
      if (datapath_rst === 1'b1) n++;
      @(negedge clk);
    end
    `CHK("datapath reset length", e, n)
  endtask
  task t_dprst_link;
    wr(OFS_DELAY_CTRL, 8'h00);
    repeat (8) @(negedge clk);
    count_dp(8'h01, 4);
    count_dp(8'h05, 0);
    wr(OFS_FINE, 8'h33);
    wr(OFS_SUPERFINE, 8'h11);
    `CHK("link after delay values", 1'b0, link_disturb)
    wr(OFS_HALF_DELAY, 8'h01);
    `CHK("half select on", 1'b1, half_delay_sel)
    `CHK("link after half delay", 1'b0, link_disturb)
    wr(OFS_HALF_DELAY, 8'h00);
    `CHK("half select off", 1'b0, half_delay_sel)
  endtask
  task t_duty;
    wr(OFS_DUTY_A, 8'h00);
    @(negedge clk);
    `CHK("first off", 1'b0, duty_stabilizer_first)
    `CHK("ok off", 1'b0, duty_stabilizers_ok)
    `CHK("second kept", 1'b1, duty_stabilizer_second)
    wr(OFS_DUTY_B, 8'h00);
    @(negedge clk);
    `CHK("second off", 1'b0, duty_stabilizer_second)
    wr(OFS_DUTY_A, 8'h01);
    wr(OFS_DUTY_B, 8'h01);
    @(negedge clk);
    `CHK("ok on", 1'b1, duty_stabilizers_ok)
  endtask
  initial begin
    #(50 * 20000);
    n_fail++;
    results();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset_access();
    t_divider();
    t_sync();
    t_delay();
    t_dprst_link();
    t_duty();
    results();
  end
endmodule
